// ### irq_enable_defs.svh
`ifndef IRQ_ENABLE_DEFS_SVH
`define IRQ_ENABLE_DEFS_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define IDX_REQUEST_GROUP_ZERO     12'hfc0
`define IDX_GROUP0_ENABLE_HIGH     12'hfc1
`define IDX_GROUP0_ENABLE_LOW      12'hfc2
`define IDX_REQUEST_GROUP_ONE      12'hfc3
`define IDX_GROUP1_ENABLE_HIGH     12'hfc4
`define IDX_GROUP1_ENABLE_LOW      12'hfc5
`define IDX_INTERRUPT_MASTER_CTL   12'hfcf

// ****************************************
// Bus geometry
// ****************************************
`define AXI_ADDR_W                 14
`define AXI_DATA_W                 32
`define RESP_OKAY                  2'h0
`define RESP_DECERR                2'h3

// ****************************************
// Fields and reset values
// ****************************************
`define MASTER_ENABLE_BIT          7
`define GROUP1_RESERVED_BIT        6
`define GROUP1_WRITE_MASK          8'hbf
`define CTL_WRITE_MASK             8'h80
`define RESET_BYTE                 8'h00
`define SOURCE_COUNT               16

`endif

// ### irq_enable_pkg.sv
package irq_enable_pkg;

    // ****************************************
    // Priority level of one source
    // ****************************************
    typedef enum logic [1:0] {
        LVL_OFF     = 2'h0,
        LVL_LOW     = 2'h1,
        LVL_NOMINAL = 2'h2,
        LVL_HIGH    = 2'h3
    } level_t;

    // ****************************************
    // Register selected by a bus address
    // ****************************************
    typedef enum logic [7:0] {
        SEL_REQ0  = 8'h01,
        SEL_EN_H0 = 8'h02,
        SEL_EN_L0 = 8'h04,
        SEL_REQ1  = 8'h08,
        SEL_EN_H1 = 8'h10,
        SEL_EN_L1 = 8'h20,
        SEL_CTL   = 8'h40,
        SEL_NONE  = 8'h80
    } reg_sel_t;

    // ****************************************
    // Whole state of the top module
    // ****************************************
    typedef struct packed {
        logic [7:0]  en_high0;
        logic [7:0]  en_low0;
        logic [7:0]  en_high1;
        logic [7:0]  en_low1;
        logic [7:0]  req0;
        logic [7:0]  req1;
        logic        master;
        logic        aw_got;
        logic [13:0] aw_addr;
        logic        w_got;
        logic [7:0]  w_byte;
        logic        w_lane0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        irq;
        logic [3:0]  irq_src;
        level_t      irq_lvl;
    } top_state_t;

    // ****************************************
    // State of the priority picker
    // ****************************************
    typedef struct packed {
        logic        valid;
        logic [3:0]  id;
        level_t      level;
    } pick_state_t;

endpackage

// ### priority_pick.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_enable_defs.svh"

module priority_pick
    import irq_enable_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] request_group_zero,
    input  wire logic [7:0] request_group_one,
    input  wire logic [7:0] group0_enable_high,
    input  wire logic [7:0] group0_enable_low,
    input  wire logic [7:0] group1_enable_high,
    input  wire logic [7:0] group1_enable_low,
    output logic            pick_valid,
    output logic [3:0]      pick_id,
    output level_t          pick_level
);

    pick_state_t s;
    pick_state_t next;
    level_t      lvl [`SOURCE_COUNT];

    // ****************************************
    // Level of each pending source
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_src
            // Two enable bits decode straight into the level
            assign lvl[g]     = request_group_zero[g] ?
                                level_t'({group0_enable_high[g], group0_enable_low[g]}) : LVL_OFF;
            assign lvl[g + 8] = request_group_one[g] ?
                                level_t'({group1_enable_high[g], group1_enable_low[g]}) : LVL_OFF;
        end
    endgenerate

    // ****************************************
    // Highest level wins, higher id on a tie
    // ****************************************
    always_comb begin
        next = '0;
        for (int i = 0; i < `SOURCE_COUNT; i++) begin
            if (lvl[i] != LVL_OFF && lvl[i] >= next.level) begin
                next.valid = 1'b1;
                next.id    = 4'(i);
                next.level = lvl[i];
            end
        end
        if (!rstn) begin
            next = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next;
    end

    assign pick_valid = s.valid;
    assign pick_id    = s.id;
    assign pick_level = s.level;

endmodule
`default_nettype wire

// ### interrupt_enable_priority.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_enable_defs.svh"

module interrupt_enable_priority
    import irq_enable_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // AXI4-Lite slave
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Peripheral requests
    input  wire logic [7:0]  source_request_zero,
    input  wire logic [7:0]  source_request_one,
    // Core side
    input  wire logic        enable_interrupts_instr,
    input  wire logic        disable_interrupts_instr,
    input  wire logic        interrupt_return_instr,
    input  wire logic        interrupt_ack,
    input  wire logic        exception_ack,
    output logic             irq_to_core,
    output logic [3:0]       irq_source,
    output logic [1:0]       irq_priority,
    output logic             master_interrupt_enable
);

    top_state_t s;
    top_state_t next;
    logic       pick_valid;
    logic [3:0] pick_id;
    level_t     pick_level;
    logic       aw_fire;
    logic       w_fire;
    logic       ar_fire;
    logic       do_write;
    reg_sel_t   wsel;
    reg_sel_t   rsel;
    logic [7:0] wbyte;
    logic [7:0] ack_clear0;
    logic [7:0] ack_clear1;
    logic [15:0] pick_onehot;
    logic       pick_live;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic reg_sel_t reg_decode(input logic [13:0] addr);
        reg_sel_t r;
        r = SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr[13:2])
                `IDX_REQUEST_GROUP_ZERO:   r = SEL_REQ0;
                `IDX_GROUP0_ENABLE_HIGH:   r = SEL_EN_H0;
                `IDX_GROUP0_ENABLE_LOW:    r = SEL_EN_L0;
                `IDX_REQUEST_GROUP_ONE:    r = SEL_REQ1;
                `IDX_GROUP1_ENABLE_HIGH:   r = SEL_EN_H1;
                `IDX_GROUP1_ENABLE_LOW:    r = SEL_EN_L1;
                `IDX_INTERRUPT_MASTER_CTL: r = SEL_CTL;
                default:                   r = SEL_NONE;
            endcase
        end
        return r;
    endfunction

    // ****************************************
    // Bits of a register that hold state
    // ****************************************
    function automatic logic [7:0] writable(input reg_sel_t sel);
        logic [7:0] m;
        // Reserved bits never take a one
        m = 8'h00;
        unique case (sel)
            SEL_REQ0:  m = 8'hff;
            SEL_EN_H0: m = 8'hff;
            SEL_EN_L0: m = 8'hff;
            SEL_REQ1:  m = `GROUP1_WRITE_MASK;
            SEL_EN_H1: m = `GROUP1_WRITE_MASK;
            SEL_EN_L1: m = `GROUP1_WRITE_MASK;
            SEL_CTL:   m = `CTL_WRITE_MASK;
            SEL_NONE:  m = 8'h00;
        endcase
        return m;
    endfunction

    // ****************************************
    // One-hot mask of a source id
    // ****************************************
    function automatic logic [15:0] source_onehot(input logic [3:0] id);
        logic [15:0] m;
        // Group 1 in the upper byte
        m     = 16'h0000;
        m[id] = 1'b1;
        return m;
    endfunction

    // ****************************************
    // Read value of a register
    // ****************************************
    function automatic logic [7:0] reg_value(input reg_sel_t sel, input top_state_t st);
        logic [7:0] v;
        v = 8'h00;
        unique case (sel)
            SEL_REQ0:  v = st.req0;
            SEL_EN_H0: v = st.en_high0;
            SEL_EN_L0: v = st.en_low0;
            SEL_REQ1:  v = st.req1 & `GROUP1_WRITE_MASK;
            SEL_EN_H1: v = st.en_high1 & `GROUP1_WRITE_MASK;
            SEL_EN_L1: v = st.en_low1 & `GROUP1_WRITE_MASK;
            SEL_CTL:   v = {st.master, 7'h00};
            SEL_NONE:  v = 8'h00;
        endcase
        v = v & writable(sel);
        return v;
    endfunction

    // ****************************************
    // Priority picker
    // ****************************************
    priority_pick u_pick (
        .sys_clk            (sys_clk),
        .rstn               (rstn),
        .request_group_zero (s.req0),
        .request_group_one  (s.req1),
        .group0_enable_high (s.en_high0),
        .group0_enable_low  (s.en_low0),
        .group1_enable_high (s.en_high1),
        .group1_enable_low  (s.en_low1),
        .pick_valid         (pick_valid),
        .pick_id            (pick_id),
        .pick_level         (pick_level)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next       = s;
        aw_fire    = s_axi_awvalid & s.awready;
        w_fire     = s_axi_wvalid & s.wready;
        ar_fire    = s_axi_arvalid & s.arready;
        wsel       = SEL_NONE;
        rsel       = reg_decode(s_axi_araddr);
        wbyte      = 8'h00;
        ack_clear0 = 8'h00;
        ack_clear1 = 8'h00;
        pick_onehot = source_onehot(pick_id);

        // ****************************************
        // Write address and data, either order
        // ****************************************
        if (aw_fire) begin
            next.aw_got  = 1'b1;
            next.aw_addr = s_axi_awaddr;
        end
        if (w_fire) begin
            next.w_got   = 1'b1;
            next.w_byte  = s_axi_wdata[7:0];
            next.w_lane0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next.bvalid = 1'b0;
        end
        do_write = next.aw_got & next.w_got & ~s.bvalid;
        if (do_write) begin
            wsel         = reg_decode(next.aw_addr);
            wbyte        = next.w_byte & writable(wsel);
            next.aw_got  = 1'b0;
            next.w_got   = 1'b0;
            next.bvalid  = 1'b1;
            next.bresp   = (wsel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
            if (!next.w_lane0) begin
                wsel = SEL_NONE;
            end
        end
        next.awready = ~next.aw_got & ~next.bvalid;
        next.wready  = ~next.w_got & ~next.bvalid;

        // ****************************************
        // Read channel
        // ****************************************
        if (s.rvalid && s_axi_rready) begin
            next.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next.rvalid = 1'b1;
            next.rdata  = {24'h000000, reg_value(rsel, s)};
            next.rresp  = (rsel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
        end
        next.arready = ~next.rvalid;

        // ****************************************
        // Enable registers
        // ****************************************
        unique case (wsel)
            SEL_EN_H0: next.en_high0 = wbyte;
            SEL_EN_L0: next.en_low0  = wbyte;
            SEL_EN_H1: next.en_high1 = wbyte & `GROUP1_WRITE_MASK;
            SEL_EN_L1: next.en_low1  = wbyte & `GROUP1_WRITE_MASK;
            SEL_CTL:   next.master   = wbyte[`MASTER_ENABLE_BIT];
            default:   next.master   = s.master;
        endcase

        // ****************************************
        // Instruction and acknowledge effects on the master enable
        // ****************************************
        if (enable_interrupts_instr || interrupt_return_instr) begin
            next.master = 1'b1;
        end
        if (disable_interrupts_instr || interrupt_ack || exception_ack) begin
            next.master = 1'b0;
        end

        // ****************************************
        // Acknowledged source leaves the pending set
        // ****************************************
        if (interrupt_ack && s.irq) begin
            {ack_clear1, ack_clear0} = source_onehot(s.irq_src);
        end

        // ****************************************
        // Requests: write one clears, a new request wins over any clear
        // ****************************************
        if (wsel == SEL_REQ0) begin
            next.req0 = next.req0 & ~wbyte;
        end
        if (wsel == SEL_REQ1) begin
            next.req1 = next.req1 & ~wbyte;
        end
        next.req0 = (next.req0 & ~ack_clear0) | source_request_zero;
        next.req1 = ((next.req1 & ~ack_clear1) | source_request_one)
                    & `GROUP1_WRITE_MASK;

        // Pick still pending after this edge's clears
        pick_live = |({next.req1, next.req0} & pick_onehot);

        // ****************************************
        // Forward to the core only while the master enable is set
        // Stale pick of a just cleared request is held back
        // ****************************************
        next.irq     = next.master & pick_valid & pick_live;
        next.irq_src = pick_id;
        next.irq_lvl = pick_level;

        if (!rstn) begin
            next          = '0;
            next.en_high0 = `RESET_BYTE;
            next.en_low0  = `RESET_BYTE;
            next.en_high1 = `RESET_BYTE;
            next.en_low1  = `RESET_BYTE;
            next.req0     = `RESET_BYTE;
            next.req1     = `RESET_BYTE;
            next.irq_lvl  = LVL_OFF;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready           = s.awready;
    assign s_axi_wready            = s.wready;
    assign s_axi_bresp             = s.bresp;
    assign s_axi_bvalid            = s.bvalid;
    assign s_axi_arready           = s.arready;
    assign s_axi_rdata             = s.rdata;
    assign s_axi_rresp             = s.rresp;
    assign s_axi_rvalid            = s.rvalid;
    assign irq_to_core             = s.irq;
    assign irq_source              = s.irq_src;
    assign irq_priority            = s.irq_lvl;
    assign master_interrupt_enable = s.master;

endmodule
`default_nettype wire

// ### irq_enable_props.sv
`timescale 1ns/1ps
`default_nettype none

module irq_enable_props
    import irq_enable_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_arready,
    input wire logic        enable_interrupts_instr,
    input wire logic        disable_interrupts_instr,
    input wire logic        interrupt_return_instr,
    input wire logic        interrupt_ack,
    input wire logic        exception_ack,
    input wire logic        irq_to_core,
    input wire logic [1:0]  irq_priority,
    input wire logic        master_interrupt_enable
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_set;
        (enable_interrupts_instr || interrupt_return_instr) && !disable_interrupts_instr && !interrupt_ack
            && !exception_ack |=> master_interrupt_enable;
    endproperty
    a_set: assert property (p_set) else $error("master enable not set");
    property p_clr;
        disable_interrupts_instr || interrupt_ack || exception_ack |=> !master_interrupt_enable;
    endproperty
    a_clr: assert property (p_clr) else $error("master enable not cleared");
    property p_gate;
        irq_to_core |-> master_interrupt_enable;
    endproperty
    a_gate: assert property (p_gate) else $error("request passed with master low");
    property p_ack;
        interrupt_ack |=> !irq_to_core;
    endproperty
    a_ack: assert property (p_ack) else $error("request held after acknowledge");
    property p_lvl;
        irq_to_core |-> irq_priority != 2'h0;
    endproperty
    a_lvl: assert property (p_lvl) else $error("request with level zero");
    property p_rst;
        disable iff (1'b0) !rstn |=> !master_interrupt_enable && !irq_to_core;
    endproperty
    a_rst: assert property (p_rst) else $error("reset did not clear");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rup;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready;
    endproperty
    a_rup: assert property (p_rup) else $error("read upper bits or ready wrong");

    c_high: cover property (irq_to_core && irq_priority == 2'h3);
    c_ack: cover property (interrupt_ack);
    c_dec: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule

bind interrupt_enable_priority irq_enable_props props (
    .sys_clk                  (sys_clk),
    .rstn                     (rstn),
    .s_axi_bready             (s_axi_bready),
    .s_axi_bvalid             (s_axi_bvalid),
    .s_axi_bresp              (s_axi_bresp),
    .s_axi_rready             (s_axi_rready),
    .s_axi_rvalid             (s_axi_rvalid),
    .s_axi_rdata              (s_axi_rdata),
    .s_axi_arready            (s_axi_arready),
    .enable_interrupts_instr  (enable_interrupts_instr),
    .disable_interrupts_instr (disable_interrupts_instr),
    .interrupt_return_instr   (interrupt_return_instr),
    .interrupt_ack            (interrupt_ack),
    .exception_ack            (exception_ack),
    .irq_to_core              (irq_to_core),
    .irq_priority             (irq_priority),
    .master_interrupt_enable  (master_interrupt_enable)
);

`default_nettype wire

// ### core_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_model (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       irq_to_core,
    input  wire logic       ack_on,
    input  wire logic [3:0] ack_wait,
    output logic            interrupt_ack
);
    // ****************************************
    // Vector fetch with a chosen delay
    // ****************************************
    logic [3:0] waited;

    always_ff @(posedge sys_clk) begin
        if (!rstn || !irq_to_core || interrupt_ack) begin
            waited        <= 4'h0;
            interrupt_ack <= 1'h0;
        end else if (ack_on && waited == ack_wait) begin
            interrupt_ack <= 1'h1;
        end else begin
            waited <= waited + 4'h1;
        end
    end
endmodule

`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_enable_defs.svh"

module tb
    import irq_enable_pkg::*;
;
    logic        sys_clk = 1'h0, rstn = 1'h0, ack_on = 1'h0;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1, irq_source, ack_wait = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, irq_priority;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  source_request_zero = '0, source_request_one = '0;
    logic        enable_interrupts_instr = 1'h0, disable_interrupts_instr = 1'h0;
    logic        interrupt_return_instr = 1'h0, exception_ack = 1'h0;
    logic        interrupt_ack, irq_to_core, master_interrupt_enable;
    int          failures = 0, n_tests = 0;
    logic [11:0] regs [7] = '{`IDX_REQUEST_GROUP_ZERO, `IDX_GROUP0_ENABLE_HIGH, `IDX_GROUP0_ENABLE_LOW,
        `IDX_REQUEST_GROUP_ONE, `IDX_GROUP1_ENABLE_HIGH, `IDX_GROUP1_ENABLE_LOW, `IDX_INTERRUPT_MASTER_CTL};
    logic [7:0]  cases [6] = '{8'h16, 8'h01, 8'h1f, 8'h3f, 8'h21, 8'h36};

    always #5 sys_clk = ~sys_clk;

    interrupt_enable_priority dut (.*);
    core_model core (.*);

    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        while (s_axi_bvalid !== 1'h1) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h1;
        @(posedge sys_clk);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
    endtask

    task rd(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        while (s_axi_rvalid !== 1'h1) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h1;
        @(posedge sys_clk);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask

    task pulse_src(input logic g, input logic [2:0] b);
        @(posedge sys_clk);
        if (g) source_request_one[b] <= 1'h1;
        else source_request_zero[b] <= 1'h1;
        @(posedge sys_clk);
        source_request_one  <= '0;
        source_request_zero <= '0;
    endtask

    task instr(input logic [3:0] v);
        @(posedge sys_clk);
        {enable_interrupts_instr, disable_interrupts_instr, interrupt_return_instr, exception_ack} <= v;
        @(posedge sys_clk);
        {enable_interrupts_instr, disable_interrupts_instr, interrupt_return_instr, exception_ack} <= 4'h0;
    endtask

    task wait_irq(input logic [3:0] id, input logic [1:0] lv);
        for (int i = 0; i < 8 && irq_to_core !== 1'h1; i++) @(posedge sys_clk);
        chk(irq_to_core, 1'h1);
        chk(irq_source, id);
        chk(irq_priority, lv);
    endtask

    task quiet;
        repeat (6) @(posedge sys_clk);
        chk(irq_to_core, 1'h0);
    endtask

    task summarize;
        $display("Comparisons %0d, failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        logic [7:0] c;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'h1;
        for (int i = 0; i < 7; i++) rd(regs[i], 32'h0, 2'h0);
        rd(12'hfc6, 32'h0, 2'h3);
        wr(12'hfc6, 32'hff, 2'h3);
        wr(`IDX_GROUP1_ENABLE_HIGH, 32'hbf, 2'h0);
        rd(`IDX_GROUP1_ENABLE_HIGH, 32'hbf, 2'h0);
        wr(`IDX_GROUP1_ENABLE_LOW, 32'hbf, 2'h0);
        rd(`IDX_GROUP1_ENABLE_LOW, 32'hbf, 2'h0);
        wr(`IDX_GROUP0_ENABLE_LOW, 32'h5a, 2'h0);
        rd(`IDX_GROUP0_ENABLE_LOW, 32'h5a, 2'h0);
        s_axi_wstrb <= 4'h0;
        wr(`IDX_GROUP0_ENABLE_LOW, 32'h0, 2'h0);
        s_axi_wstrb <= 4'h1;
        rd(`IDX_GROUP0_ENABLE_LOW, 32'h5a, 2'h0);
        wr(`IDX_INTERRUPT_MASTER_CTL, 32'h80, 2'h0);
        rd(`IDX_INTERRUPT_MASTER_CTL, 32'h80, 2'h0);
        wr(`IDX_INTERRUPT_MASTER_CTL, 32'h0, 2'h0);
        rd(`IDX_INTERRUPT_MASTER_CTL, 32'h0, 2'h0);
        ack_on <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            c = cases[i];
            ack_wait <= i[3:0];
            wr(c[5] ? `IDX_GROUP1_ENABLE_HIGH : `IDX_GROUP0_ENABLE_HIGH, 32'(c[1]) << c[4:2], 2'h0);
            wr(c[5] ? `IDX_GROUP1_ENABLE_LOW : `IDX_GROUP0_ENABLE_LOW, 32'(c[0]) << c[4:2], 2'h0);
            instr(4'h8);
            pulse_src(c[5], c[4:2]);
            wait_irq({c[5], c[4:2]}, c[1:0]);
            repeat (10) @(posedge sys_clk);
            chk(master_interrupt_enable, 1'h0);
            rd(c[5] ? `IDX_REQUEST_GROUP_ONE : `IDX_REQUEST_GROUP_ZERO, 32'h0, 2'h0);
        end
        ack_on <= 1'h0;
        wr(`IDX_GROUP0_ENABLE_HIGH, 32'h0c, 2'h0);
        wr(`IDX_GROUP0_ENABLE_LOW, 32'h06, 2'h0);
        pulse_src(1'h0, 3'h3);
        quiet();
        rd(`IDX_REQUEST_GROUP_ZERO, 32'h08, 2'h0);
        instr(4'h8);
        wait_irq(4'h3, 2'h2);
        instr(4'h4);
        quiet();
        instr(4'h2);
        wait_irq(4'h3, 2'h2);
        instr(4'h1);
        quiet();
        wr(`IDX_INTERRUPT_MASTER_CTL, 32'h80, 2'h0);
        wait_irq(4'h3, 2'h2);
        wr(`IDX_INTERRUPT_MASTER_CTL, 32'h0, 2'h0);
        quiet();
        pulse_src(1'h0, 3'h1);
        pulse_src(1'h0, 3'h2);
        pulse_src(1'h0, 3'h0);
        pulse_src(1'h1, 3'h6);
        ack_on <= 1'h1;
        ack_wait <= 4'h0;
        instr(4'h8);
        wait_irq(4'h2, 2'h3);
        repeat (4) @(posedge sys_clk);
        instr(4'h8);
        wait_irq(4'h3, 2'h2);
        repeat (4) @(posedge sys_clk);
        instr(4'h8);
        wait_irq(4'h1, 2'h1);
        repeat (4) @(posedge sys_clk);
        instr(4'h8);
        quiet();
        rd(`IDX_REQUEST_GROUP_ZERO, 32'h01, 2'h0);
        rd(`IDX_REQUEST_GROUP_ONE, 32'h0, 2'h0);
        wr(`IDX_INTERRUPT_MASTER_CTL, 32'h80, 2'h0);
        @(posedge sys_clk);
        rstn <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'h1;
        rd(`IDX_INTERRUPT_MASTER_CTL, 32'h0, 2'h0);
        rd(`IDX_GROUP0_ENABLE_HIGH, 32'h0, 2'h0);
        summarize();
    end

    initial begin
        #100us;
        failures++;
        summarize();
    end
endmodule

`default_nettype wire
